// ===== design/srtc_pkg.sv
// Shared constants for the serial pattern timekeeper and its host controller
package srtc_pkg;

  // ----------------------------------------------------------------
  // Serial protocol
  // ----------------------------------------------------------------
  localparam int unsigned PAT_BITS = 64;
  localparam int unsigned DATA_BITS = 64;
  localparam int unsigned CYCLE_BITS = PAT_BITS + DATA_BITS;
  localparam int unsigned PTR_W = 8;
  localparam logic [PTR_W-1:0] PTR_LAST_PAT = PTR_W'(PAT_BITS - 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(CYCLE_BITS - 1);
  // Recognition pattern, bit 0 sent first; arbitrary value
  localparam logic [PAT_BITS-1:0] PATTERN = 64'h0123_4567_89ab_cdef;
  localparam int unsigned WE_ADDR_BIT = 2;
  localparam int unsigned DIN_ADDR_BIT = 0;
  localparam int unsigned DOUT_DATA_BIT = 7;

  // ----------------------------------------------------------------
  // Time registers
  // ----------------------------------------------------------------
  typedef logic [7:0] srtc_byte_t;
  localparam logic [2:0] REG_HUND = 3'h0;
  localparam logic [2:0] REG_SEC = 3'h1;
  localparam logic [2:0] REG_MIN = 3'h2;
  localparam logic [2:0] REG_HOUR = 3'h3;
  localparam logic [2:0] REG_DAY = 3'h4;
  localparam logic [2:0] REG_DATE = 3'h5;
  localparam logic [2:0] REG_MONTH = 3'h6;
  localparam logic [2:0] REG_YEAR = 3'h7;
  localparam int unsigned HOUR_12H_BIT = 7;
  localparam int unsigned HOUR_PM_BIT = 5;
  localparam int unsigned DAY_OSC_OFF_BIT = 5;
  // Bits that exist in each register; the rest read as zero
  localparam srtc_byte_t ZERO_MASK [8] = '{8'hff, 8'h7f, 8'h7f, 8'hbf,
                                          8'h27, 8'h3f, 8'h1f, 8'hff};
  localparam srtc_byte_t RESET_VAL [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
                                          8'h01, 8'h01, 8'h01, 8'h00};

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned XTAL_HZ = 32768;
  localparam int unsigned HUND_PER_S = 100;
  localparam int unsigned TICKS_PER_HUND = XTAL_HZ / HUND_PER_S;
  localparam logic [8:0] TICK_LAST = 9'(TICKS_PER_HUND - 1);
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned ACCESS_NS = 150;
  localparam int unsigned ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] ACC_LAST = 2'(ACCESS_CYC - 1);

  // ----------------------------------------------------------------
  // Host register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_MCR = 12'h000;
  localparam logic [11:0] OFS_CMD = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h008;
  localparam int unsigned MCR_SEL_BIT = 2;
  localparam int unsigned CMD_DATA_BIT = 0;
  localparam int unsigned CMD_READ_BIT = 1;

endpackage

// ===== design/srtc_if.sv
// Bytewide memory bus between host controller and serial timekeeper
`timescale 1ns/1ns
interface srtc_if;
  logic [15:0] addr;
  logic ce1_n;
  logic ce2_n;
  logic rw_n;
  logic [7:0] hdata_o;
  logic hdata_oe;
  logic d7_o;
  logic d7_oe;
  logic [7:0] data;

  // Undriven data lines float high through pull-ups
  assign data = hdata_oe ? hdata_o : {(d7_oe ? d7_o : 1'b1), 7'h7f};

  modport host (
    output addr, ce1_n, ce2_n, rw_n, hdata_o, hdata_oe,
    input data
  );
  modport dev (
    input addr, ce2_n,
    output d7_o, d7_oe
  );
endinterface

// ===== design/srtc_dev.sv
// Serial pattern timekeeper: pattern check, bit pointer and BCD calendar
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ns
module srtc_dev (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Crystal tick, one pulse per 32 kHz period
  input wire logic i_osc_tick,
  // Memory bus
  srtc_if.dev bus,
  // Status
  output logic o_osc_run,
  output logic o_unlocked,
  output logic [srtc_pkg::PTR_W-1:0] o_ptr
);
  import srtc_pkg::*;

  typedef enum logic [1:0] {ST_HUNT, ST_DATA, ST_DONE, ST_HALT} srtc_ptr_e;

  srtc_ptr_e st_q;
  logic [PTR_W-1:0] ptr_q;
  logic sel_q;
  logic a2_q;
  logic a0_q;
  logic d7_q;
  logic d7_oe_q;
  logic osc_run_q;
  logic unlocked_q;
  srtc_byte_t tr_q [8];
  srtc_byte_t tn [8];
  logic [8:0] pre_q;
  logic sel;
  logic acc_end;
  logic do_rd;
  logic do_wr;
  logic [2:0] ri;
  logic [2:0] bi;
  logic rd_bit;
  logic osc_off;
  logic hund_tick;
  logic c;
  logic [8:0] t9;
  logic [7:0] h;
  logic pm;

  // ----------------------------------------------------------------
  // BCD helpers
  // ----------------------------------------------------------------
  // Returns {carry, next}; out-of-range values also wrap to lo
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                         input logic [7:0] hi);
    if (v >= hi) begin
      return {1'b1, lo};
    end else if (v[3:0] >= 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end
    return {1'b0, v + 8'h01};
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      8'h02: return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Bus sampling
  // ----------------------------------------------------------------
  assign sel = ~bus.ce2_n;
  // The access is acted on when the select is released, so the host may
  // sample the output bit for the whole cycle before the pointer moves.
  assign acc_end = sel_q & ~sel;
  assign do_rd = acc_end & a2_q;
  assign do_wr = acc_end & ~a2_q;
  assign ri = ptr_q[5:3];
  assign bi = ptr_q[2:0];

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sel_q <= 1'b0;
      a2_q <= 1'b0;
      a0_q <= 1'b0;
    end else if (i_ce) begin
      sel_q <= sel;
      // Strobe direction is not looked at; address carries the intent
      if (sel) begin
        a2_q <= bus.addr[WE_ADDR_BIT];
        a0_q <= bus.addr[DIN_ADDR_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Bit pointer
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= ST_HUNT;
      ptr_q <= '0;
    end else if (i_ce) begin
      case (st_q)
        ST_HUNT: begin
          if (do_rd) begin
            ptr_q <= '0;
          end else if (do_wr) begin
            if (a0_q == PATTERN[ptr_q[5:0]]) begin
              ptr_q <= ptr_q + 8'h01;
              if (ptr_q == PTR_LAST_PAT) begin
                st_q <= ST_DATA;
              end
            end else begin
              st_q <= ST_HALT;
            end
          end
        end
        ST_DATA: begin
          if (acc_end) begin
            ptr_q <= ptr_q + 8'h01;
            if (ptr_q == PTR_LAST) begin
              st_q <= ST_DONE;
            end
          end
        end
        ST_DONE, ST_HALT: begin
          // Only a read brings the pointer back to the start
          if (do_rd) begin
            ptr_q <= '0;
            st_q <= ST_HUNT;
          end
        end
        default: begin
          st_q <= ST_HUNT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  assign rd_bit = (st_q == ST_DATA) ? tr_q[ri][bi] : 1'b0;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      d7_q <= 1'b0;
      d7_oe_q <= 1'b0;
    end else if (i_ce) begin
      d7_q <= rd_bit;
      d7_oe_q <= sel & bus.addr[WE_ADDR_BIT];
    end
  end

  assign bus.d7_o = d7_q;
  assign bus.d7_oe = d7_oe_q;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // 32768/100 does not divide; the hundredth runs slightly fast
  assign osc_off = tr_q[REG_DAY][DAY_OSC_OFF_BIT];
  assign hund_tick = ~osc_off & i_osc_tick & (pre_q == TICK_LAST);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pre_q <= '0;
    end else if (i_ce && !osc_off && i_osc_tick) begin
      pre_q <= (pre_q == TICK_LAST) ? 9'h000 : pre_q + 9'h001;
    end
  end

  // ----------------------------------------------------------------
  // Calendar chain and serial writes
  // ----------------------------------------------------------------
  always_comb begin
    tn = tr_q;
    c = 1'b0;
    t9 = '0;
    h = '0;
    pm = 1'b0;
    if (hund_tick) begin
      t9 = bcd_inc(tr_q[REG_HUND], 8'h00, 8'h99);
      tn[REG_HUND] = t9[7:0];
      c = t9[8];
      if (c) begin
        t9 = bcd_inc(tr_q[REG_SEC], 8'h00, 8'h59);
        tn[REG_SEC] = t9[7:0];
        c = t9[8];
      end
      if (c) begin
        t9 = bcd_inc(tr_q[REG_MIN], 8'h00, 8'h59);
        tn[REG_MIN] = t9[7:0];
        c = t9[8];
      end
      if (c) begin
        if (tr_q[REG_HOUR][HOUR_12H_BIT]) begin
          h = {3'h0, tr_q[REG_HOUR][4:0]};
          pm = tr_q[REG_HOUR][HOUR_PM_BIT];
          c = pm && (h == 8'h11);
          if (h == 8'h11) begin
            pm = ~pm;
          end
          t9 = bcd_inc(h, 8'h01, 8'h12);
          tn[REG_HOUR] = {1'b1, 1'b0, pm, t9[4:0]};
        end else begin
          t9 = bcd_inc({2'h0, tr_q[REG_HOUR][5:0]}, 8'h00, 8'h23);
          tn[REG_HOUR] = {2'h0, t9[5:0]};
          c = t9[8];
        end
      end
      if (c) begin
        t9 = bcd_inc({5'h0, tr_q[REG_DAY][2:0]}, 8'h01, 8'h07);
        tn[REG_DAY] = {tr_q[REG_DAY][7:3], t9[2:0]};
        t9 = bcd_inc(tr_q[REG_DATE], 8'h01, month_days(tr_q[REG_MONTH], tr_q[REG_YEAR]));
        tn[REG_DATE] = t9[7:0];
        c = t9[8];
        if (c) begin
          t9 = bcd_inc(tr_q[REG_MONTH], 8'h01, 8'h12);
          tn[REG_MONTH] = t9[7:0];
          c = t9[8];
        end
        if (c) begin
          t9 = bcd_inc(tr_q[REG_YEAR], 8'h00, 8'h99);
          tn[REG_YEAR] = t9[7:0];
        end
      end
    end
    // A serial write lands on top of any increment in the same cycle
    if (do_wr && st_q == ST_DATA) begin
      tn[ri][bi] = a0_q & ZERO_MASK[ri][bi];
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 8; i++) begin
        tr_q[i] <= RESET_VAL[i];
      end
    end else if (i_ce) begin
      tr_q <= tn;
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      osc_run_q <= 1'b0;
      unlocked_q <= 1'b0;
    end else if (i_ce) begin
      osc_run_q <= ~osc_off;
      unlocked_q <= (st_q == ST_DATA);
    end
  end

  assign o_osc_run = osc_run_q;
  assign o_unlocked = unlocked_q;
  assign o_ptr = ptr_q;

endmodule

// ===== design/srtc_host.sv
// Host controller: APB registers driving bytewide cycles to the timekeeper
`timescale 1ns/1ns
module srtc_host (
  // Clock, resets, enable
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_por,
  input wire logic i_ce,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Memory bus
  srtc_if.host bus
);
  import srtc_pkg::*;

  typedef enum logic {H_IDLE, H_ACC} srtc_host_e;

  srtc_host_e st_q;
  logic [1:0] cnt_q;
  logic acs_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic hit;
  logic wr;
  logic [15:0] addr_q;
  logic ce1_n_q;
  logic ce2_n_q;
  logic rw_n_q;
  logic oe_q;
  logic [7:0] rbyte_q;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign wr = i_psel & i_penable & pready_q & i_pwrite;

  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    if (i_paddr == OFS_MCR) begin
      rd_mux[MCR_SEL_BIT] = acs_q;
    end else if (i_paddr == OFS_CMD) begin
      rd_mux = 32'h0000_0000;
    end else if (i_paddr == OFS_STAT) begin
      rd_mux = {16'h0000, rbyte_q, 6'h00, rbyte_q[DOUT_DATA_BIT], st_q != H_IDLE};
    end else begin
      hit = 1'b0;
    end
  end

  // One wait-free access phase: pready rises on the edge after setup
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (i_ce) begin
      if (i_psel && !i_penable) begin
        pready_q <= 1'b1;
        pslverr_q <= ~hit;
        prdata_q <= rd_mux;
      end else if (i_psel && i_penable && pready_q) begin
        pready_q <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_prdata = prdata_q;

  // ----------------------------------------------------------------
  // Clock access select
  // ----------------------------------------------------------------
  // Held only by power-on reset, not by the processor reset
  always_ff @(posedge i_mclk or posedge i_por) begin
    if (i_por) begin
      acs_q <= 1'b0;
    end else if (i_ce && wr && i_paddr == OFS_MCR) begin
      acs_q <= i_pwdata[MCR_SEL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Bus cycle engine
  // ----------------------------------------------------------------
  // A command while a cycle runs is dropped; software polls busy first
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= H_IDLE;
      cnt_q <= 2'h0;
      addr_q <= 16'h0000;
      ce1_n_q <= 1'b1;
      ce2_n_q <= 1'b1;
      rw_n_q <= 1'b1;
      oe_q <= 1'b0;
      rbyte_q <= 8'h00;
    end else if (i_ce) begin
      case (st_q)
        H_IDLE: begin
          if (wr && i_paddr == OFS_CMD) begin
            addr_q <= '0;
            addr_q[WE_ADDR_BIT] <= i_pwdata[CMD_READ_BIT];
            addr_q[DIN_ADDR_BIT] <= i_pwdata[CMD_DATA_BIT];
            ce2_n_q <= ~acs_q;
            ce1_n_q <= acs_q;
            rw_n_q <= i_pwdata[CMD_READ_BIT];
            oe_q <= ~i_pwdata[CMD_READ_BIT];
            cnt_q <= 2'h0;
            st_q <= H_ACC;
          end
        end
        H_ACC: begin
          cnt_q <= cnt_q + 2'h1;
          if (cnt_q == ACC_LAST) begin
            rbyte_q <= bus.data;
            ce1_n_q <= 1'b1;
            ce2_n_q <= 1'b1;
            rw_n_q <= 1'b1;
            oe_q <= 1'b0;
            st_q <= H_IDLE;
          end
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end

  assign bus.addr = addr_q;
  assign bus.ce1_n = ce1_n_q;
  assign bus.ce2_n = ce2_n_q;
  assign bus.rw_n = rw_n_q;
  assign bus.hdata_o = 8'h00;
  assign bus.hdata_oe = oe_q;

endmodule

// ===== tb/srtc_asserts.sv
// Concurrent checks on the bytewide bus between host controller and timekeeper
`timescale 1ns/1ns
module srtc_asserts (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Bus signals
  input wire logic [15:0] addr,
  input wire logic ce1_n,
  input wire logic ce2_n,
  input wire logic d7_oe,
  // Timekeeper status
  input wire logic o_unlocked,
  input wire logic [srtc_pkg::PTR_W-1:0] o_ptr
);
  import srtc_pkg::*;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  // ----------------------------------------------------------------
  // Selects and bus cycle shape
  // ----------------------------------------------------------------
  a_sel_exclusive: assert property (ce1_n || ce2_n)
    else $error("both chip selects low");
  a_sel_length: assert property ($fell(ce2_n) |-> !ce2_n [*3] ##1 ce2_n)
    else $error("secondary select not low for three cycles");
  a_addr_clean: assert property (!ce2_n |-> (addr & 16'hfffa) == 16'h0000)
    else $error("stray address bits during timekeeper cycle");
  a_read_drives: assert property ($fell(ce2_n) && addr[2] |=> d7_oe [*2])
    else $error("read cycle without data bit driven");
  a_write_quiet: assert property ($fell(ce2_n) && !addr[2] |=> !d7_oe [*2])
    else $error("data bit driven in a write cycle");

  // ----------------------------------------------------------------
  // Pointer behaviour
  // ----------------------------------------------------------------
  // Pointer may only move on the edge after a select release
  a_ptr_moment: assert property ($changed(o_ptr) |-> $past(ce2_n) && !$past(ce2_n, 2))
    else $error("pointer moved outside an access");
  a_unlock_point: assert property ($rose(o_unlocked) |-> o_ptr == 8'h40)
    else $error("unlock not at pointer 64");
  a_data_step: assert property ($fell(ce2_n) && o_unlocked && o_ptr < 8'h80
    |-> ##4 o_ptr == $past(o_ptr, 4) + 8'h01)
    else $error("data access did not step pointer by one");
  a_read_rewind: assert property ($fell(ce2_n) && addr[2] && !o_unlocked
    |-> ##4 o_ptr == 8'h00)
    else $error("read outside data phase did not rewind pointer");
  a_bad_halt: assert property ($fell(ce2_n) && !addr[2] && !o_unlocked && o_ptr < 8'h40
    && addr[0] != PATTERN[o_ptr[5:0]] |-> ##4 o_ptr == $past(o_ptr, 4))
    else $error("wrong pattern bit moved pointer");

  c_unlock: cover property ($rose(o_unlocked));
  c_data_read: cover property ($fell(ce2_n) && addr[2] && o_unlocked);
  c_primary: cover property ($fell(ce1_n));
  c_bad_bit: cover property ($fell(ce2_n) && !addr[2] && !o_unlocked && o_ptr < 8'h40
    && addr[0] != PATTERN[o_ptr[5:0]]);
endmodule

// ===== tb/serial_pattern_rtc_test.sv
// Self-checking bench: host controller and timekeeper joined by the bytewide bus
`timescale 1ns/1ns
module serial_pattern_rtc_test;
  import srtc_pkg::*;
  logic i_mclk, i_rst, i_por, i_ce, i_osc_tick;
  logic psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, osc_run, unlocked, e, d;
  logic [PTR_W-1:0] ptr;
  logic [31:0] seed = 32'h0000b792;
  logic [7:0] v [8];
  int mdl [8];
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;

  srtc_if bus_if();
  srtc_host u_srtc_host (.i_mclk(i_mclk), .i_rst(i_rst), .i_por(i_por), .i_ce(i_ce),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .bus(bus_if));
  srtc_dev u_srtc_dev (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_osc_tick(i_osc_tick),
    .bus(bus_if), .o_osc_run(osc_run), .o_unlocked(unlocked), .o_ptr(ptr));
  srtc_asserts u_srtc_asserts (.i_mclk(i_mclk), .i_rst(i_rst), .addr(bus_if.addr),
    .ce1_n(bus_if.ce1_n), .ce2_n(bus_if.ce2_n), .d7_oe(bus_if.d7_oe),
    .o_unlocked(unlocked), .o_ptr(ptr));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One APB transfer; an idle cycle follows so the next setup is a fresh edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_mclk);
    penable <= 1'b1;
    do @(posedge i_mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_mclk);
  endtask

  // One bus cycle to the timekeeper, waiting on the busy flag
  task automatic xfer(input logic rd_cyc, input logic din, output logic dout);
    logic [31:0] s;
    logic se;
    apb(1'b1, OFS_CMD, {30'h0, rd_cyc, din}, s, se);
    do apb(1'b0, OFS_STAT, 32'h0, s, se); while (s[0] !== 1'b0);
    dout = s[1];
  endtask

  task automatic unlock();
    logic b;
    xfer(1'b1, 1'b0, b);
    for (int i = 0; i < PAT_BITS; i++) xfer(1'b0, PATTERN[i], b);
    check({31'h0, unlocked}, 32'h1, "unlock");
  endtask

  task automatic set_time(input logic [7:0] t [8]);
    logic b;
    unlock();
    for (int k = 0; k < 64; k++) xfer(1'b0, t[k/8][k%8], b);
    for (int k = 0; k < 8; k++) mdl[k] = int'(t[k] & ZERO_MASK[k]);
  endtask

  task automatic check_time();
    logic [7:0] b;
    unlock();
    for (int k = 0; k < 8; k++) begin
      for (int i = 0; i < 8; i++) xfer(1'b1, 1'b0, b[i]);
      check({24'h0, b}, 32'(mdl[k]), "time byte");
    end
    check({24'h0, ptr}, 32'h80, "pointer after cycle");
  endtask

  // Let one hundredth elapse on a crystal tick every cycle
  task automatic advance(input logic [7:0] s [8], input logic [7:0] x [8]);
    set_time(s);
    i_osc_tick <= 1'b1;
    repeat (TICKS_PER_HUND) @(posedge i_mclk);
    i_osc_tick <= 1'b0;
    for (int k = 0; k < 8; k++) mdl[k] = int'(x[k]);
    check_time();
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 90000) begin
      n_mismatch++;
      $display("Error at %0t: run did not complete", $time);
      finish_test();
    end
  end

  initial begin
    {i_rst, i_por, i_ce, i_osc_tick} = 4'b1110;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    mdl = '{0, 0, 0, 0, 1, 1, 1, 0};
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'b0;
    i_por <= 1'b0;
    @(posedge i_mclk);
    apb(1'b0, 12'h00c, 32'h0, r, e);
    check({31'h0, e}, 32'h1, "unmapped error");
    check(r, 32'h0, "unmapped data");
    apb(1'b1, OFS_MCR, 32'h4, r, e);
    $display("Test register access done");
    xfer(1'b1, 1'b0, d);
    for (int i = 0; i < 10; i++) xfer(1'b0, PATTERN[i], d);
    xfer(1'b0, ~PATTERN[10], d);
    check({24'h0, ptr}, 32'ha, "halt on bad bit");
    xfer(1'b0, PATTERN[10], d);
    check({24'h0, ptr}, 32'ha, "stays halted");
    apb(1'b1, OFS_MCR, 32'h0, r, e);
    xfer(1'b1, 1'b0, d);
    check({24'h0, ptr}, 32'ha, "primary select cycle");
    apb(1'b0, OFS_STAT, 32'h0, r, e);
    check({24'h0, r[15:8]}, 32'hff, "idle bus byte");
    apb(1'b1, OFS_MCR, 32'h4, r, e);
    xfer(1'b1, 1'b0, d);
    check({24'h0, ptr}, 32'h0, "read rewinds");
    $display("Test pattern halt done");
    check_time();
    $display("Test reset time done");
    for (int k = 0; k < 8; k++) v[k] = 8'(xs());
    set_time(v);
    check({24'h0, ptr}, 32'h80, "pointer at end");
    xfer(1'b0, 1'b1, d);
    check({24'h0, ptr}, 32'h80, "no access past end");
    check({31'h0, osc_run}, {31'h0, ~v[4][DAY_OSC_OFF_BIT]}, "oscillator state");
    check_time();
    $display("Test random time done");
    advance('{8'h99, 8'h59, 8'h59, 8'h23, 8'h01, 8'h05, 8'h03, 8'h00},
            '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h06, 8'h03, 8'h00});
    advance('{8'h99, 8'h59, 8'h59, 8'h91, 8'h01, 8'h05, 8'h03, 8'h00},
            '{8'h00, 8'h00, 8'h00, 8'hb2, 8'h01, 8'h05, 8'h03, 8'h00});
    advance('{8'h99, 8'h59, 8'h59, 8'hb1, 8'h07, 8'h28, 8'h02, 8'h00},
            '{8'h00, 8'h00, 8'h00, 8'h92, 8'h01, 8'h29, 8'h02, 8'h00});
    advance('{8'h99, 8'h59, 8'h59, 8'h23, 8'h21, 8'h05, 8'h03, 8'h00},
            '{8'h99, 8'h59, 8'h59, 8'h23, 8'h21, 8'h05, 8'h03, 8'h00});
    $display("Test time advance done");
    i_rst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    apb(1'b0, OFS_MCR, 32'h0, r, e);
    check({31'h0, r[MCR_SEL_BIT]}, 32'h1, "select kept over reset");
    // Clock enable low must hold every count even with the crystal ticking
    i_ce <= 1'b0;
    i_osc_tick <= 1'b1;
    repeat (400) @(posedge i_mclk);
    i_ce <= 1'b1;
    i_osc_tick <= 1'b0;
    @(posedge i_mclk);
    mdl = '{0, 0, 0, 0, 1, 1, 1, 0};
    check_time();
    apb(1'b1, OFS_MCR, 32'h0, r, e);
    apb(1'b0, OFS_MCR, 32'h0, r, e);
    check({31'h0, r[MCR_SEL_BIT]}, 32'h0, "select cleared");
    $display("Test processor reset done");
    finish_test();
  end
endmodule
